// File: async_serial_baud_and_control_tb.sv
// Purpose: self-checking bench for the serial port control and baud block
// Assumes: one wait state per bus access, bit time is 16 baud ticks
// Notes:   start bit of 0xFF gives one clean bit time to measure
`timescale 1ns/1ps
module async_serial_baud_and_control_tb;
    import serial_port_pkg::*;
    localparam logic [4:0] A_TX = {1'b0, OFS_TX_CTRL};
    localparam logic [4:0] A_RX = {1'b0, OFS_RX_CTRL};
    localparam logic [4:0] A_RC = {1'b0, OFS_RATE_CTRL};
    localparam logic [4:0] A_LO = {1'b0, OFS_DIV_LOW};
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [4:0]  adr     = 5'h00;
    logic        rd_en   = 1'b0;
    logic        wr_en   = 1'b0;
    logic [31:0] wdat    = 32'h00000000;
    logic [31:0] rdat;
    logic        wreq;
    logic        rx_line;
    logic        tx_line;
    logic        rx_flag;
    int          n_fail  = 0;
    int          checks  = 0;

    serial_port_ctrl u_serial_port_ctrl (.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .rx_i(rx_line), .tx_o(tx_line), .rx_flag_o(rx_flag));
    serial_remote_model u_serial_remote_model (.sys_clk_i(sys_clk), .rx_o(rx_line));

    // ==========================================================
    // clock, bus access and compare helpers
    initial forever #2 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low, bounded wait
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        adr   <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdat  <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
            k++;
        end while (wreq !== 1'b0 && k < 64);
        if (k >= 64) n_fail++;
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q & m, exp);
    endtask

    // ==========================================================
    // scenarios
    task automatic reset_values;
        rd(A_TX, 32'hFF, 32'h02);
        rd(A_RX, 32'hFF, 32'h00);
        rd(A_RC, 32'hFF, 32'h40);
        rd(5'h1C, 32'hFFFFFFFF, 32'h0);
        $display("test reset_values done");
    endtask

    // start bit length of a 0xFF frame equals one bit time
    task automatic tx_case(input logic [7:0] tc, input logic [7:0] rc, input logic [7:0] lo,
                           input logic [7:0] hi, input int exp);
        int k;
        wr(A_RC, rc);
        wr(A_TX, tc | 8'h20);
        wr(A_LO, lo);
        wr(OFS_DIV_HIGH, hi);
        wr(A_RX, 8'h90);
        wr(OFS_TX_DATA, 8'hFF);
        k = 0;
        while (tx_line !== 1'b0 && k < 4 * exp) begin
            @(posedge sys_clk);
            k++;
        end
        k = 0;
        while (tx_line === 1'b0 && k < 2 * exp) begin
            @(posedge sys_clk);
            k++;
        end
        chk(k, exp);
        rd(A_TX, 32'h02, 32'h00);
        repeat (11 * exp) @(posedge sys_clk);
        rd(A_TX, 32'h02, 32'h02);
        $display("test tx_rate %0d done", exp);
    endtask

    task automatic rx_case(input logic [7:0] cfg, input logic [8:0] v, input int nb,
                           input logic fl, input logic [7:0] d);
        wr(A_RX, cfg);
        u_serial_remote_model.send(v, nb, 256);
        chk({31'h0, rx_flag}, {31'h0, fl});
        rd(A_RC, 32'h40, 32'h40);
        if (fl) begin
            rd(A_RX, 32'h01, {31'h0, v[8] & (nb == 9)});
            rd(OFS_RX_DATA, 32'hFF, {24'h0, d});
            // flag register updates at the answer edge, look one edge later
            @(posedge sys_clk);
            chk({31'h0, rx_flag}, 32'h0);
        end
        $display("test rx_char %h done", v);
    endtask

    // 8 bits of 256 clocks counted at base/8 with base Fosc/4
    task automatic autobaud;
        logic [31:0] q;
        wr(A_RC, 8'h09);
        u_serial_remote_model.send(9'h055, 8, 256);
        chk({31'h0, rx_flag}, 32'h1);
        rd(A_RC, 32'h81, 32'h00);
        bus(1'b0, A_LO, 8'h00, q);
        chk({31'h0, q >= 63 && q <= 66}, 32'h1);
        rd(OFS_DIV_HIGH, 32'hFF, 32'h00);
        rd(OFS_RX_DATA, 32'h0, 32'h0);
        $display("test autobaud done");
    endtask

    task automatic wrap_up;
        $display("counts: checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        reset_values();
        tx_case(8'h00, 8'h00, 8'h00, 8'h00, 1024);
        tx_case(8'h04, 8'h00, 8'h01, 8'h01, 512);
        tx_case(8'h00, 8'h08, 8'h01, 8'h00, 512);
        tx_case(8'h04, 8'h08, 8'h03, 8'h00, 256);
        rx_case(8'h90, 9'h0A5, 8, 1'b1, 8'hA5);
        rx_case(8'hD8, 9'h0A5, 9, 1'b0, 8'h00);
        rx_case(8'hD8, 9'h15A, 9, 1'b1, 8'h5A);
        autobaud();
        wrap_up();
    end

    // total run is near 42k cycles, so 100k means a hang
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        wrap_up();
    end
endmodule

// File: baud_tick_if.sv
`timescale 1ns/1ps
// Purpose: carrier between baud timer and port logic
// Assumes: single clock
// Notes:   ctl drives config, timer returns tick only
interface baud_tick_if;
    import serial_port_pkg::*;
    logic [15:0] divisor;
    logic [5:0]  prescale;
    logic        wide;
    logic        restart;
    logic        tick;
    modport ctl (output divisor, prescale, wide, restart, input tick);
    modport tmr (input divisor, prescale, wide, restart, output tick);
endinterface

// File: baud_timer.sv
`timescale 1ns/1ps
// Purpose: free-running baud timer, prescale then divisor reload
// Assumes: restart clears both stages
// Notes:   tick is one cycle every (pre+1)*(n+1) clocks
module baud_timer
    import serial_port_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    baud_tick_if.tmr  bt
);
    typedef struct packed {
        logic [5:0]  pre;
        logic [15:0] cnt;
        logic        tick;
    } tmr_state_t;
    tmr_state_t st_r, st_nxt;
    logic [15:0] limit;

    // ==========================================================
    // next state
    always_comb begin
        limit = bt.wide ? bt.divisor : {8'h00, bt.divisor[7:0]};
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (bt.restart) begin
            st_nxt.pre = 6'h00;
            st_nxt.cnt = 16'h0000;
        end else if (st_r.pre >= bt.prescale) begin
            st_nxt.pre = 6'h00;
            if (st_r.cnt >= limit) begin
                st_nxt.cnt  = 16'h0000;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end else begin
            st_nxt.pre = st_r.pre + 6'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign bt.tick = st_r.tick;

    // ==========================================================
    // checks
    a_restart_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        bt.restart |=> st_r.cnt == 16'h0000 && !st_r.tick)
        else $error("timer not cleared by divisor write");
    a_eight_bit_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !bt.wide |-> st_r.cnt <= {8'h00, bt.divisor[7:0]} || $changed(bt.divisor))
        else $error("8-bit timer ran past low byte");
endmodule

// File: serial_port_ctrl.sv
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Purpose: control, status, baud generation and autobaud of a serial port
// Assumes: Avalon-MM slave, one wait state on every access
// Notes:   datapath kept minimal: 16x oversampled rx, 1x tx, one-char buffer
module serial_port_ctrl
    import serial_port_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        rx_i,
    output logic             tx_o,
    output logic             rx_flag_o
);
    typedef enum logic [1:0] {ABD_OFF, ABD_WAIT, ABD_COUNT} abd_t;
    typedef struct packed {
        logic [7:0]  txc;
        logic [7:0]  rxc;
        logic [7:0]  rc;
        logic [15:0] div;
        logic [8:0]  rx_buf;
        logic        rx_full;
        logic        rx_framing_error_flag;
        logic        rx_act;
        logic [3:0]  rx_ovs;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic        rx_prev;
        logic [9:0]  tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_pend;
        logic [7:0]  tx_hold;
        logic        tx_brk;
        abd_t        abd;
        logic [2:0]  abd_edges;
        logic [2:0]  abd_div;
        logic [5:0]  abd_pre;
        logic        ack;
        logic [31:0] rdata;
        logic        tx;
    } ctl_state_t;
    ctl_state_t st_r, st_nxt;

    baud_tick_if bt();
    logic sync_m, high_sel, wide_sel, port_on, rx_rise, rx_fall;
    logic bus_wr, bus_rd, div_wr, rx_done, take;
    logic [15:0] div_next;

    // ==========================================================
    // baud timer
    baud_timer u_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .bt        (bt)
    );

    // mode decode; sync ignores speed select
    always_comb begin
        sync_m   = st_r.txc[TX_SYNC_BIT];
        high_sel = st_r.txc[TX_HIGH_BIT] && !sync_m;
        wide_sel = st_r.rc[RC_WIDE_BIT];
        port_on  = st_r.rxc[RX_PORT_BIT];
        if (sync_m || (wide_sel && high_sel)) begin
            bt.prescale = PRE_FAST;
        end else if (wide_sel || high_sel) begin
            bt.prescale = PRE_MID;
        end else begin
            bt.prescale = PRE_SLOW;
        end
        bt.divisor = st_r.div;
        bt.wide    = wide_sel;
    end

    // async timer tick is 16x oversample, so rate tables hold per bit
    // a request takes effect only at the edge that answers it
    assign bus_wr  = avs_write_i && !avs_waitrequest_o;
    assign bus_rd  = avs_read_i && !avs_waitrequest_o;
    assign div_wr  = bus_wr && (avs_address_i == {1'b0, OFS_DIV_LOW} || avs_address_i == OFS_DIV_HIGH);
    assign bt.restart = div_wr || !port_on || st_r.abd != ABD_OFF;
    assign rx_rise = rx_i && !st_r.rx_prev;
    assign rx_fall = !rx_i && st_r.rx_prev;
    assign rx_done = st_r.rx_act && bt.tick && st_r.rx_ovs == SAMPLE_MID
                     && st_r.rx_bit == (st_r.rxc[RX_NINE_BIT] ? FRAME_BITS9 : FRAME_BITS8) - 4'h1;

    // ==========================================================
    // next state: bus, receiver, transmitter, autobaud
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.rx_prev = rx_i;
        div_next = st_r.div;
        take = 1'b0;
        // bus writes to control, divisor and transmit data registers
        if (bus_wr) begin
            unique case (avs_address_i)
                {1'b0, OFS_TX_CTRL}: st_nxt.txc = (avs_writedata_i[7:0] & TX_CTRL_WMASK)
                                                  | (st_r.txc & ~TX_CTRL_WMASK);
                {1'b0, OFS_RX_CTRL}: st_nxt.rxc = (avs_writedata_i[7:0] & RX_CTRL_WMASK)
                                                  | (st_r.rxc & ~RX_CTRL_WMASK);
                {1'b0, OFS_RATE_CTRL}: st_nxt.rc = (avs_writedata_i[7:0] & RC_WMASK)
                                                   | (st_r.rc & ~RC_WMASK);
                {1'b0, OFS_DIV_LOW}: div_next[7:0] = avs_writedata_i[7:0];
                OFS_DIV_HIGH:        div_next[15:8] = avs_writedata_i[7:0];
                OFS_TX_DATA: begin
                    st_nxt.tx_hold = avs_writedata_i[7:0];
                    st_nxt.tx_pend = 1'b1;
                end
                default: ;
            endcase
        end
        st_nxt.div = div_next;
        // a cleared receive enable clears overrun
        if (!st_nxt.rxc[RX_CONT_BIT]) begin
            st_nxt.rxc[RX_OVERRUN_ERROR_FLAG_BIT] = 1'b0;
        end
        // data read releases buffer; next byte refreshes framing flag
        if (bus_rd && avs_address_i == OFS_RX_DATA) begin
            st_nxt.rx_full = 1'b0;
        end
        // receiver, 16x oversampled
        if (st_r.abd == ABD_OFF && !st_r.rc[RC_WAKE_BIT] && st_r.rxc[RX_CONT_BIT]
            && !st_r.rxc[RX_OVERRUN_ERROR_FLAG_BIT]) begin
            if (!st_r.rx_act && rx_fall) begin
                st_nxt.rx_act = 1'b1;
                st_nxt.rx_ovs = 4'h0;
                st_nxt.rx_bit = 4'h0;
            end else if (st_r.rx_act && bt.tick) begin
                st_nxt.rx_ovs = st_r.rx_ovs + 4'h1;
                if (st_r.rx_ovs == SAMPLE_MID) begin
                    st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                    if (st_r.rx_bit != 4'h0 && !rx_done) begin
                        st_nxt.rx_sh = {rx_i, st_r.rx_sh[8:1]};
                    end
                end
            end
        end
        if (rx_done) begin
            st_nxt.rx_act = 1'b0;
            // nine-bit character is aligned; eight-bit one shifted down
            if (!st_r.rxc[RX_NINE_BIT] || !st_r.rxc[RX_ADDR_BIT] || st_r.rx_sh[8]) begin
                take = 1'b1;
            end
            if (take && st_r.rx_full && !(bus_rd && avs_address_i == OFS_RX_DATA)) begin
                st_nxt.rxc[RX_OVERRUN_ERROR_FLAG_BIT] = 1'b1;
            end else if (take) begin
                st_nxt.rx_buf  = st_r.rxc[RX_NINE_BIT] ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
                st_nxt.rx_full = 1'b1;
                st_nxt.rx_framing_error_flag = !rx_i;
            end
        end
        // wake on falling edge, no character received
        if (st_r.rc[RC_WAKE_BIT] && rx_fall && !sync_m) begin
            st_nxt.rx_full = 1'b1;
            st_nxt.rc[RC_WAKE_BIT] = 1'b0;
        end
        // transmitter, one shift per 16 ticks
        if (st_r.tx_cnt == 4'h0 && (st_r.tx_pend || st_r.txc[TX_BREAK_BIT])) begin
            st_nxt.tx_brk  = st_r.txc[TX_BREAK_BIT] && !sync_m;
            st_nxt.tx_sh   = st_nxt.tx_brk ? 10'h200 : {1'b1, st_r.tx_hold, 1'b0};
            st_nxt.tx_cnt  = FRAME_BITS8;
            st_nxt.tx_pend = st_nxt.tx_brk ? st_r.tx_pend : 1'b0;
            st_nxt.rx_ovs  = st_r.rx_act ? st_nxt.rx_ovs : 4'h0;
        end else if (st_r.tx_cnt != 4'h0 && bt.tick && st_r.rx_ovs == OVS_LAST) begin
            st_nxt.tx    = st_r.tx_sh[0];
            st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
            st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
            if (st_r.tx_cnt == 4'h1 && st_r.tx_brk) begin
                st_nxt.txc[TX_BREAK_BIT] = 1'b0;
                st_nxt.tx_brk = 1'b0;
            end
        end
        if (!st_r.rx_act && bt.tick) begin
            st_nxt.rx_ovs = st_r.rx_ovs + 4'h1;
        end
        st_nxt.txc[TX_EMPTY_BIT] = st_nxt.tx_cnt == 4'h0;
        // autobaud: wait first rising edge, count to fifth
        unique case (st_r.abd)
            ABD_OFF: begin
                if (st_nxt.rc[RC_ABD_BIT] && !st_r.rc[RC_ABD_BIT] && !sync_m) begin
                    st_nxt.abd = ABD_WAIT;
                end
            end
            ABD_WAIT: begin
                if (rx_rise) begin
                    st_nxt.abd       = ABD_COUNT;
                    st_nxt.div       = 16'h0001;
                    st_nxt.abd_edges = 3'h1;
                    st_nxt.abd_div   = 3'h0;
                    st_nxt.abd_pre   = 6'h00;
                end
            end
            ABD_COUNT: begin
                // timer is held here, so the base clock prescale is counted locally
                if (st_r.abd_pre >= bt.prescale) begin
                    st_nxt.abd_pre = 6'h00;
                    st_nxt.abd_div = st_r.abd_div + 3'h1;
                    if (st_r.abd_div == ABD_DIV_LAST) begin
                        st_nxt.div = st_r.div + 16'h0001;
                        if (st_r.div == 16'hFFFF) begin
                            st_nxt.rc[RC_OVF_BIT] = 1'b1;
                        end
                    end
                end else begin
                    st_nxt.abd_pre = st_r.abd_pre + 6'h01;
                end
                if (rx_rise) begin
                    st_nxt.abd_edges = st_r.abd_edges + 3'h1;
                    if (st_r.abd_edges + 3'h1 == ABD_EDGES) begin
                        st_nxt.abd = ABD_OFF;
                        st_nxt.div = st_r.div;
                        st_nxt.rc[RC_ABD_BIT] = 1'b0;
                        st_nxt.rx_full = 1'b1;
                    end
                end
            end
        endcase
        if (st_nxt.abd != ABD_OFF && !st_nxt.rc[RC_ABD_BIT]) begin
            st_nxt.abd = ABD_OFF;
        end
        st_nxt.rc[RC_IDLE_BIT] = !st_nxt.rx_act;
        // read answer, one wait state
        if ((avs_read_i || avs_write_i) && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            unique case (avs_address_i)
                {1'b0, OFS_TX_CTRL}:   st_nxt.rdata = {24'h0, st_r.txc};
                {1'b0, OFS_RX_CTRL}:   st_nxt.rdata = {24'h0, st_r.rxc[7:3], st_r.rx_framing_error_flag,
                                                       st_r.rxc[RX_OVERRUN_ERROR_FLAG_BIT], st_r.rx_buf[8]};
                {1'b0, OFS_RATE_CTRL}: st_nxt.rdata = {24'h0, st_r.rc};
                {1'b0, OFS_DIV_LOW}:   st_nxt.rdata = {24'h0, st_r.div[7:0]};
                OFS_DIV_HIGH:          st_nxt.rdata = {24'h0, st_r.div[15:8]};
                OFS_RX_DATA:           st_nxt.rdata = {24'h0, st_r.rx_buf[7:0]};
                default:               st_nxt.rdata = 32'h0;
            endcase
        end
        // port disable resets the port
        if (!st_nxt.rxc[RX_PORT_BIT]) begin
            st_nxt.rx_full = 1'b0;
            st_nxt.rx_framing_error_flag = 1'b0;
            st_nxt.rx_act  = 1'b0;
            st_nxt.rxc[RX_OVERRUN_ERROR_FLAG_BIT] = 1'b0;
            st_nxt.tx_cnt  = 4'h0;
            st_nxt.tx_pend = 1'b0;
            st_nxt.tx      = 1'b1;
            st_nxt.txc[TX_EMPTY_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.txc <= TX_CTRL_RESET;
            st_r.rc[RC_IDLE_BIT] <= 1'b1;
            st_r.tx <= 1'b1;
            st_r.rx_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_o    = st_r.rdata;
    assign avs_waitrequest_o = !st_r.ack;
    assign tx_o              = st_r.tx;
    assign rx_flag_o         = st_r.rx_full;

    // ==========================================================
    // checks
    a_div_write_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        div_wr |-> bt.restart)
        else $error("divisor write did not restart timer");
    a_async_slow_pre: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sync_m && !wide_sel && !high_sel |-> bt.prescale == PRE_SLOW)
        else $error("wrong low speed prescale");
    a_wide_slow_pre: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sync_m && (wide_sel ^ high_sel) |-> bt.prescale == PRE_MID)
        else $error("wrong mid prescale");
    a_sync_fast_pre: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sync_m |-> bt.prescale == PRE_FAST && !high_sel)
        else $error("sync mode not fast");
    a_wide_high_pre: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sync_m && wide_sel && high_sel |-> bt.prescale == PRE_FAST)
        else $error("wide high speed prescale wrong");
    a_overrun_error_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !st_r.rxc[RX_CONT_BIT] |-> !st_r.rxc[RX_OVERRUN_ERROR_FLAG_BIT])
        else $error("overrun held without receive enable");
    a_wake_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_r.rc[RC_WAKE_BIT] && rx_fall && !sync_m && port_on |=> !st_r.rc[RC_WAKE_BIT] && st_r.rx_full)
        else $error("wake edge not handled");
    a_abd_finish: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_r.abd == ABD_COUNT && rx_rise && st_r.abd_edges == 3'h4 && port_on
        |=> !st_r.rc[RC_ABD_BIT] && st_r.rx_full && $stable(st_r.div))
        else $error("autobaud fifth edge not handled");
    a_empty_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_r.txc[TX_EMPTY_BIT] == (st_r.tx_cnt == 4'h0))
        else $error("shift empty flag wrong");
    a_break_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_r.tx_brk && st_r.tx_cnt == 4'h1 && bt.tick && st_r.rx_ovs == OVS_LAST && port_on
        |=> !st_r.txc[TX_BREAK_BIT])
        else $error("break bit not cleared");
    c_rx_char: cover property (@(posedge sys_clk_i) rx_done && take);
    c_abd_done: cover property (@(posedge sys_clk_i) st_r.abd == ABD_COUNT ##1 st_r.abd == ABD_OFF);
    c_overrun: cover property (@(posedge sys_clk_i) $rose(st_r.rxc[RX_OVERRUN_ERROR_FLAG_BIT]));
endmodule

// File: serial_port_pkg.sv
// Purpose: shared constants for the serial port control and baud block
// Assumes: 32-bit Avalon-MM word registers, 8-bit data in the low bits
// Notes:   offsets are byte addresses of aligned words
package serial_port_pkg;
    // ==========================================================
    // register map
    localparam logic [3:0] OFS_TX_CTRL   = 4'h0;
    localparam logic [3:0] OFS_RX_CTRL   = 4'h4;
    localparam logic [3:0] OFS_RATE_CTRL = 4'h8;
    localparam logic [3:0] OFS_DIV_LOW   = 4'hC;
    localparam logic [4:0] OFS_DIV_HIGH  = 5'h10;
    localparam logic [4:0] OFS_RX_DATA   = 5'h14;
    localparam logic [4:0] OFS_TX_DATA   = 5'h18;
    // ==========================================================
    // field positions
    localparam int TX_SYNC_BIT   = 4;
    localparam int TX_BREAK_BIT  = 3;
    localparam int TX_HIGH_BIT   = 2;
    localparam int TX_EMPTY_BIT  = 1;
    localparam int RX_PORT_BIT   = 7;
    localparam int RX_NINE_BIT   = 6;
    localparam int RX_CONT_BIT   = 4;
    localparam int RX_ADDR_BIT   = 3;
    localparam int RX_FRAMING_ERROR_FLAG_BIT   = 2;
    localparam int RX_OVERRUN_ERROR_FLAG_BIT   = 1;
    localparam int RX_D8_BIT     = 0;
    localparam int RC_OVF_BIT    = 7;
    localparam int RC_IDLE_BIT   = 6;
    localparam int RC_WIDE_BIT   = 3;
    localparam int RC_WAKE_BIT   = 1;
    localparam int RC_ABD_BIT    = 0;
    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0] TX_CTRL_RESET = 8'h02;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] RC_WMASK      = 8'h3B;
    // ==========================================================
    // divider factors: base clock prescale and autobaud slow-down
    localparam logic [5:0] PRE_SLOW      = 6'h3F;  // 64 - 1
    localparam logic [5:0] PRE_MID       = 6'h0F;  // 16 - 1
    localparam logic [5:0] PRE_FAST      = 6'h03;  // 4 - 1
    localparam logic [2:0] ABD_DIV_LAST  = 3'h7;   // 8 - 1
    localparam logic [2:0] ABD_EDGES     = 3'h5;
    localparam logic [3:0] FRAME_BITS8   = 4'hA;
    localparam logic [3:0] FRAME_BITS9   = 4'hB;
    localparam logic [3:0] SAMPLE_MID    = 4'h7;
    localparam logic [3:0] OVS_LAST      = 4'hF;
endpackage

// File: serial_remote_model.sv
// Purpose: remote serial node that drives the receive line of the port
// Assumes: idle high line, lsb first, one start and one stop bit
// Notes:   bit time given in system clocks by the caller
`timescale 1ns/1ps
module serial_remote_model (
    input  wire logic sys_clk_i,
    output logic      rx_o
);
    // line idles high so the port sees no start bit before a frame
    initial rx_o = 1'b1;

    // ==========================================================
    // one frame: start, nb data bits lsb first, stop, idle gap
    task automatic send(input logic [8:0] v, input int nb, input int bt);
        int i;
        @(posedge sys_clk_i);
        rx_o <= 1'b0;
        repeat (bt) @(posedge sys_clk_i);
        for (i = 0; i < nb; i++) begin
            rx_o <= v[i];
            repeat (bt) @(posedge sys_clk_i);
        end
        rx_o <= 1'b1;
        repeat (bt * 2) @(posedge sys_clk_i);
    endtask
endmodule
